// [core/bst_pkg.sv]
// Purpose: Shared constants and types for the boundary-scan test access port
// Assumes: Three-bit instruction register, sixteen-state controller
// Notes: Boundary register holds input cells low, output cells above them
package bst_pkg;

    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int NUM_IN = 4;
    localparam int NUM_OUT = 4;
    localparam int BSR_W = NUM_IN + NUM_OUT;
    localparam int BSR_OUT_LSB = NUM_IN;
    localparam int SYNC_W = 3;

    typedef logic [IR_W-1:0] bst_instr_t;

    localparam bst_instr_t INSTR_EXTEST = 3'h0;
    localparam bst_instr_t INSTR_IDCODE = 3'h1;
    localparam bst_instr_t INSTR_SAMPLE = 3'h2;
    localparam bst_instr_t INSTR_CLAMP = 3'h3;
    localparam bst_instr_t INSTR_HIGHZ = 3'h4;
    localparam bst_instr_t INSTR_BYPASS = 3'h7;

    // Fixed pattern loaded in Capture-IR; low bits 01 as usual for scan chains
    localparam bst_instr_t IR_CAPTURE_VAL = 3'h1;
    localparam logic BYPASS_CAPTURE_VAL = 1'b0;
    localparam logic [BSR_W-1:0] BSR_RESET_VAL = 8'h00;
    localparam logic [NUM_OUT-1:0] PIN_OUT_RESET_VAL = 4'h0;

    typedef enum logic [15:0] {
        ST_RESET      = 16'h0001,
        ST_IDLE       = 16'h0002,
        ST_SEL_DR     = 16'h0004,
        ST_CAPTURE_DR = 16'h0008,
        ST_SHIFT_DR   = 16'h0010,
        ST_EXIT1_DR   = 16'h0020,
        ST_PAUSE_DR   = 16'h0040,
        ST_EXIT2_DR   = 16'h0080,
        ST_UPDATE_DR  = 16'h0100,
        ST_SEL_IR     = 16'h0200,
        ST_CAPTURE_IR = 16'h0400,
        ST_SHIFT_IR   = 16'h0800,
        ST_EXIT1_IR   = 16'h1000,
        ST_PAUSE_IR   = 16'h2000,
        ST_EXIT2_IR   = 16'h4000,
        ST_UPDATE_IR  = 16'h8000
    } bst_state_t;

endpackage

// [core/bst_tap.sv]
// Purpose: Test access port controller, instruction and data registers, pin control
// Assumes: testClockPin is its own clock domain; core_clk runs the pin muxes
// Notes: Test reset pin and core reset both end in Test-Logic-Reset
`timescale 1ns/10ps
module bst_tap
    import bst_pkg::*;
#(
    // Arbitrary identification value; bit 0 must stay 1
    parameter logic [bst_pkg::ID_W-1:0] ID_VALUE = 32'h0000_1001
)
(
    input wire logic core_clk,                                // System clock
    input wire logic rst_n,                                   // Synchronous reset, active low
    input wire logic testClockPin,                            // Test clock from controller
    input wire logic testResetPinN,                           // Test reset, asynchronous, active low
    input wire logic testModeSelectPin,                       // Mode-select level
    input wire logic testDataInPin,                           // Serial data in
    output logic testDataOutPin,                              // Serial data out
    output logic testDataOutEn,                               // High while data-out is driven
    input wire logic [bst_pkg::NUM_IN-1:0] pinIn,             // Digital input pins
    input wire logic [bst_pkg::NUM_OUT-1:0] sysOut,           // System logic output values
    input wire logic [bst_pkg::NUM_OUT-1:0] sysOutEn,         // System logic output enables
    output logic [bst_pkg::NUM_OUT-1:0] pinOut,               // Digital output pin values
    output logic [bst_pkg::NUM_OUT-1:0] pinOutEn              // Digital output pin enables
);
    import bst_pkg::*;

    // Test clock domain
    bst_state_t state_r;
    bst_state_t state_nxt;
    bst_instr_t irShift_r;
    bst_instr_t instr_r;
    logic bypass_r;
    logic [ID_W-1:0] idShift_r;
    logic [BSR_W-1:0] bsrShift_r;
    logic [BSR_W-1:0] bsrPar_r;
    logic tdo_r;
    logic tdoEn_r;
    logic [SYNC_W-1:0] coreRstSync_r;
    logic [BSR_W-1:0] capSync1_r;
    logic [BSR_W-1:0] capSync2_r;
    logic [BSR_W-1:0] capSync3_r;
    logic [BSR_W-1:0] capStable_r;
    logic tapHold_r;
    logic selBsr;
    logic selId;

    // Core clock domain
    bst_instr_t instrSync1_r;
    bst_instr_t instrSync2_r;
    bst_instr_t instrSync3_r;
    bst_instr_t coreInstr_r;
    logic [BSR_W-1:0] parSync1_r;
    logic [BSR_W-1:0] parSync2_r;
    logic [BSR_W-1:0] parSync3_r;
    logic [BSR_W-1:0] corePar_r;
    logic [NUM_OUT-1:0] pinOut_r;
    logic [NUM_OUT-1:0] pinOutEn_r;

    // Core reset reaches the controller through a three-stage chain; both late stages must agree
    always_ff @(posedge testClockPin or negedge testResetPinN)
    begin
        if (!testResetPinN)
            coreRstSync_r <= '0;
        else
            coreRstSync_r <= {coreRstSync_r[SYNC_W-2:0], ~rst_n};
    end

    // Hold moves only when the two late stages agree, so one odd sample changes nothing
    always_ff @(posedge testClockPin or negedge testResetPinN)
    begin
        if (!testResetPinN)
            tapHold_r <= 1'b0;
        else if (coreRstSync_r[SYNC_W-1] == coreRstSync_r[SYNC_W-2])
            tapHold_r <= coreRstSync_r[SYNC_W-1];
    end

    // Unknown codes fall to the bypass bit and leave the pins on system logic
    assign selBsr = (instr_r == INSTR_SAMPLE) || (instr_r == INSTR_EXTEST);
    assign selId = (instr_r == INSTR_IDCODE);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: state_nxt = testModeSelectPin ? ST_RESET : ST_IDLE;
            ST_IDLE: state_nxt = testModeSelectPin ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_nxt = testModeSelectPin ? ST_SEL_IR : ST_CAPTURE_DR;
            ST_CAPTURE_DR: state_nxt = testModeSelectPin ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_nxt = testModeSelectPin ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_nxt = testModeSelectPin ? ST_UPDATE_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_nxt = testModeSelectPin ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_nxt = testModeSelectPin ? ST_UPDATE_DR : ST_SHIFT_DR;
            ST_UPDATE_DR: state_nxt = testModeSelectPin ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_nxt = testModeSelectPin ? ST_RESET : ST_CAPTURE_IR;
            ST_CAPTURE_IR: state_nxt = testModeSelectPin ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_nxt = testModeSelectPin ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_nxt = testModeSelectPin ? ST_UPDATE_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_nxt = testModeSelectPin ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_nxt = testModeSelectPin ? ST_UPDATE_IR : ST_SHIFT_IR;
            ST_UPDATE_IR: state_nxt = testModeSelectPin ? ST_SEL_DR : ST_IDLE;
            default: state_nxt = ST_RESET;
        endcase
    end

    // Rising test clock only; the pin reset forces Test-Logic-Reset without a clock
    always_ff @(posedge testClockPin or negedge testResetPinN)
    begin
        if (!testResetPinN)
            state_r <= ST_RESET;
        else if (tapHold_r)
            state_r <= ST_RESET;
        else
            state_r <= state_nxt;
    end

    // Instruction shift stage; holds outside its capture and shift states
    always_ff @(posedge testClockPin or negedge testResetPinN)
    begin
        if (!testResetPinN)
            irShift_r <= IR_CAPTURE_VAL;
        else if (state_r == ST_CAPTURE_IR)
            irShift_r <= IR_CAPTURE_VAL;
        else if (state_r == ST_SHIFT_IR)
            irShift_r <= {testDataInPin, irShift_r[IR_W-1:1]};
    end

    // Parallel instruction stage on the falling edge; reset state forces the ID instruction
    always_ff @(negedge testClockPin or negedge testResetPinN)
    begin
        if (!testResetPinN)
            instr_r <= INSTR_IDCODE;
        else if (state_r == ST_RESET)
            instr_r <= INSTR_IDCODE;
        else if (state_r == ST_UPDATE_IR)
            instr_r <= irShift_r;
    end

    // Bypass bit serves every code that is not boundary or identification
    always_ff @(posedge testClockPin or negedge testResetPinN)
    begin
        if (!testResetPinN)
            bypass_r <= BYPASS_CAPTURE_VAL;
        else if (!selBsr && !selId)
        begin
            if (state_r == ST_CAPTURE_DR)
                bypass_r <= BYPASS_CAPTURE_VAL;
            else if (state_r == ST_SHIFT_DR)
                bypass_r <= testDataInPin;
        end
    end

    // Identification value loads only at capture; shifting never alters the parameter
    always_ff @(posedge testClockPin or negedge testResetPinN)
    begin
        if (!testResetPinN)
            idShift_r <= '0;
        else if (selId && state_r == ST_CAPTURE_DR)
            idShift_r <= ID_VALUE;
        else if (selId && state_r == ST_SHIFT_DR)
            idShift_r <= {testDataInPin, idShift_r[ID_W-1:1]};
    end

    // Pin levels reach the test domain through three stages; a bit counts once stages two and three agree
    always_ff @(posedge testClockPin or negedge testResetPinN)
    begin
        if (!testResetPinN)
        begin
            capSync1_r <= BSR_RESET_VAL;
            capSync2_r <= BSR_RESET_VAL;
            capSync3_r <= BSR_RESET_VAL;
        end
        else
        begin
            capSync1_r <= {pinOut_r, pinIn};
            capSync2_r <= capSync1_r;
            capSync3_r <= capSync2_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < BSR_W; gi++)
        begin : gCapAgree
            always_ff @(posedge testClockPin or negedge testResetPinN)
            begin
                if (!testResetPinN)
                    capStable_r[gi] <= BSR_RESET_VAL[gi];
                else if (capSync2_r[gi] == capSync3_r[gi])
                    capStable_r[gi] <= capSync3_r[gi];
            end
        end
    endgenerate

    // Limitation: the test clock is slow next to pin edges, so a capture sees levels a few edges old
    always_ff @(posedge testClockPin or negedge testResetPinN)
    begin
        if (!testResetPinN)
            bsrShift_r <= BSR_RESET_VAL;
        else if (selBsr && state_r == ST_CAPTURE_DR)
            bsrShift_r <= capStable_r;
        else if (selBsr && state_r == ST_SHIFT_DR)
            bsrShift_r <= {testDataInPin, bsrShift_r[BSR_W-1:1]};
    end

    // Parallel latch keeps pins steady while the shift path moves
    always_ff @(negedge testClockPin or negedge testResetPinN)
    begin
        if (!testResetPinN)
            bsrPar_r <= BSR_RESET_VAL;
        else if (selBsr && state_r == ST_UPDATE_DR)
            bsrPar_r <= bsrShift_r;
    end

    // Data-out parks low with its enable off outside the two shift states
    always_ff @(negedge testClockPin or negedge testResetPinN)
    begin
        if (!testResetPinN)
        begin
            tdo_r <= 1'b0;
            tdoEn_r <= 1'b0;
        end
        else if (state_r == ST_SHIFT_IR)
        begin
            tdo_r <= irShift_r[0];
            tdoEn_r <= 1'b1;
        end
        else if (state_r == ST_SHIFT_DR)
        begin
            tdoEn_r <= 1'b1;
            if (selBsr)
                tdo_r <= bsrShift_r[0];
            else if (selId)
                tdo_r <= idShift_r[0];
            else
                tdo_r <= bypass_r;
        end
        else
        begin
            tdo_r <= 1'b0;
            tdoEn_r <= 1'b0;
        end
    end

    assign testDataOutPin = tdo_r;
    assign testDataOutEn = tdoEn_r;

    // Both words change only at update edges or the pin reset, the instruction also in Test-Logic-Reset; the agree test drops any one-cycle mixed sample
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            instrSync1_r <= INSTR_IDCODE;
            instrSync2_r <= INSTR_IDCODE;
            instrSync3_r <= INSTR_IDCODE;
            parSync1_r <= BSR_RESET_VAL;
            parSync2_r <= BSR_RESET_VAL;
            parSync3_r <= BSR_RESET_VAL;
        end
        else
        begin
            instrSync1_r <= instr_r;
            instrSync2_r <= instrSync1_r;
            instrSync3_r <= instrSync2_r;
            parSync1_r <= bsrPar_r;
            parSync2_r <= parSync1_r;
            parSync3_r <= parSync2_r;
        end
    end

    // A word is taken only once two late stages agree; until then the old one stays
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            coreInstr_r <= INSTR_IDCODE;
            corePar_r <= BSR_RESET_VAL;
        end
        else
        begin
            if (instrSync2_r == instrSync3_r)
                coreInstr_r <= instrSync3_r;
            if (parSync2_r == parSync3_r)
                corePar_r <= parSync3_r;
        end
    end

    // Pin drive: EXTEST, CLAMP and HIGHZ override the system, everything else passes it through
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pinOut_r <= PIN_OUT_RESET_VAL;
            pinOutEn_r <= '0;
        end
        else if (coreInstr_r == INSTR_EXTEST || coreInstr_r == INSTR_CLAMP)
        begin
            pinOut_r <= corePar_r[BSR_OUT_LSB +: NUM_OUT];
            pinOutEn_r <= '1;
        end
        else if (coreInstr_r == INSTR_HIGHZ)
        begin
            pinOut_r <= PIN_OUT_RESET_VAL;
            pinOutEn_r <= '0;
        end
        else
        begin
            pinOut_r <= sysOut;
            pinOutEn_r <= sysOutEn;
        end
    end

    assign pinOut = pinOut_r;
    assign pinOutEn = pinOutEn_r;

endmodule // bst_tap

// [bench/bst_tap_sva.sv]
// Purpose: Port-level checks of the scan controller and the pin control
// Assumes: Mode-select is sampled on the rising test clock
// Notes: Test clock checks are quiet while the test reset is low
`timescale 1ns/10ps
module bst_tap_sva
    import bst_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic rst_n, // System reset
    input wire logic testClockPin, // Test clock
    input wire logic testResetPinN, // Test reset
    input wire logic testModeSelectPin, // Mode-select
    input wire logic testDataInPin, // Serial in
    input wire logic testDataOutPin, // Serial out
    input wire logic testDataOutEn, // Serial out enable
    input wire logic [bst_pkg::NUM_IN-1:0] pinIn, // Input pins
    input wire logic [bst_pkg::NUM_OUT-1:0] sysOut, // System values
    input wire logic [bst_pkg::NUM_OUT-1:0] sysOutEn, // System enables
    input wire logic [bst_pkg::NUM_OUT-1:0] pinOut, // Pin values
    input wire logic [bst_pkg::NUM_OUT-1:0] pinOutEn // Pin enables
);
    // Five highs end in Test-Logic-Reset from anywhere, so the walk after it is known
    sequence s_reset;
        testModeSelectPin [*5];
    endsequence
    sequence s_sel_dr;
        s_reset ##1 (!testModeSelectPin) [*3] ##1 testModeSelectPin;
    endsequence
    property p_dr_path;
        @(posedge testClockPin) disable iff (!testResetPinN)
        s_sel_dr ##1 !testModeSelectPin ##1 !testModeSelectPin |=> testDataOutEn;
    endproperty
    a_dr_path: assert property (p_dr_path) else $error("Shift-DR not reached");
    property p_ir_path;
        @(posedge testClockPin) disable iff (!testResetPinN)
        s_sel_dr ##1 testModeSelectPin ##1 !testModeSelectPin ##1 !testModeSelectPin
        |=> testDataOutEn && testDataOutPin;
    endproperty
    a_ir_path: assert property (p_ir_path) else $error("Shift-IR entry wrong");
    property p_cap_exit;
        @(posedge testClockPin) disable iff (!testResetPinN)
        s_reset ##1 !testModeSelectPin ##1 testModeSelectPin ##1 !testModeSelectPin ##1 testModeSelectPin
        |=> !testDataOutEn;
    endproperty
    a_cap_exit: assert property (p_cap_exit) else $error("Capture-DR exit wrong");
    property p_reset_tms;
        @(posedge testClockPin) disable iff (!testResetPinN) s_reset |=> !testDataOutEn;
    endproperty
    a_reset_tms: assert property (p_reset_tms) else $error("Five highs left output on");
    property p_oe_cause;
        @(posedge testClockPin) disable iff (!testResetPinN)
        $changed(testDataOutEn) |-> $past(testModeSelectPin) == !testDataOutEn;
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("Output enable moved wrongly");
    property p_idle_low;
        @(posedge testClockPin) disable iff (!testResetPinN) !testDataOutEn |-> !testDataOutPin;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("Data out not low when idle");
    property p_edge_fall;
        @(posedge core_clk) disable iff (!rst_n)
        $changed(testDataOutPin) || $changed(testDataOutEn) |-> !testClockPin;
    endproperty
    a_edge_fall: assert property (p_edge_fall) else $error("Data out moved on high clock");
    property p_async_rst;
        @(posedge core_clk) disable iff (!rst_n) !testResetPinN |-> !testDataOutEn && !testDataOutPin;
    endproperty
    a_async_rst: assert property (p_async_rst) else $error("Test reset left output on");
    property p_sys_follow;
        @(posedge core_clk) disable iff (!rst_n)
        pinOutEn != 4'h0 && pinOutEn != 4'hF |-> pinOutEn == $past(sysOutEn) && pinOut == $past(sysOut);
    endproperty
    a_sys_follow: assert property (p_sys_follow) else $error("Pins left system logic");
endmodule // bst_tap_sva

// [bench/bst_jtag_ctrl.sv]
// Purpose: Behavioural test controller driving the scan port
// Assumes: Test clock stands low between frames, 160 ns period within them
// Notes: Data out is sampled just before each rising edge
`timescale 1ns/10ps
module bst_jtag_ctrl
(
    output logic tck, // Test clock
    output logic tms, // Mode-select
    output logic tdi, // Serial data to device
    input wire logic tdo, // Serial data from device
    output logic [31:0] lastOut // Bits seen in last scan
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        lastOut = 32'h0;
    end
    // Levels change only while the clock is low; odd offsets keep clear of system edges
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #40.3;
        o = tdo;
        tck = 1'b1;
        #80;
        tck = 1'b0;
        #39.7;
    endtask
    task automatic walk(input logic [7:0] m, input int n);
        logic o;
        for (int i = 0; i < n; i++)
            tick(m[i], ~tdi, o);
    endtask
    task automatic tap_reset();
        walk(8'h1F, 5);
    endtask
    task automatic scan(input logic ir, input logic [31:0] din, input int n);
        logic o;
        lastOut = 32'h0;
        walk(ir ? 8'h18 : 8'h08, ir ? 7 : 6);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1 || i == 1, din[i], o);
            lastOut[i] = o;
            if (i == 1)
                walk(8'h04, 4);
        end
        walk(8'h01, 2);
    endtask
endmodule // bst_jtag_ctrl

// [bench/bst_tap_tb.sv]
// Purpose: Self-checking bench for the scan port
// Assumes: Scan results and pin states are noted, then compared by a monitor
// Notes: Boundary cells are four inputs low and four outputs high
`timescale 1ns/10ps
module bst_tap_tb;
    import bst_pkg::*;
    localparam logic [31:0] ID_TB = 32'hA5C3_0F01; // Arbitrary value, bit 0 set
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic testResetPinN = 1'b1;
    logic tck, tms, tdi, tdo, tdoEn, tdoBus;
    logic [3:0] pinIn = 4'h0, sysOut = 4'h0, sysOutEn = 4'h0, pinOut, pinOutEn;
    logic [31:0] scanOut, expQ[$];
    logic kindQ[$];
    logic [7:0] bsrLatch = 8'h00;
    int badCount = 0, checks = 0, cycles = 0;
    bst_instr_t codes[7] = '{INSTR_SAMPLE, INSTR_EXTEST, INSTR_CLAMP, INSTR_HIGHZ, INSTR_BYPASS, INSTR_IDCODE, 3'h5};
    event resEv;
    bst_tap #(.ID_VALUE(ID_TB)) i_bst_tap (.core_clk(core_clk), .rst_n(rst_n), .testClockPin(tck),
        .testResetPinN(testResetPinN), .testModeSelectPin(tms), .testDataInPin(tdi), .testDataOutPin(tdo),
        .testDataOutEn(tdoEn), .pinIn(pinIn), .sysOut(sysOut), .sysOutEn(sysOutEn), .pinOut(pinOut),
        .pinOutEn(pinOutEn));
    // Released data-out reads as the opposite of its parked level, so a stray sample shows
    assign tdoBus = tdoEn ? tdo : ~tdo;
    bst_jtag_ctrl i_bst_jtag_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoBus), .lastOut(scanOut));
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            badCount++;
            test_done();
        end
    end
    task automatic test_done();
        if (badCount == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            badCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always
    begin
        @(resEv);
        if (kindQ.pop_front())
            cmp({24'h0, pinOut, pinOutEn}, expQ.pop_front());
        else
            cmp(scanOut, expQ.pop_front());
    end
    task automatic want(input logic k, input logic [31:0] e);
        kindQ.push_back(k);
        expQ.push_back(e);
    endtask
    task automatic seen();
        -> resEv;
        #1;
    endtask
    function automatic logic [31:0] pinsExp(input bst_instr_t c);
        if (c == INSTR_EXTEST || c == INSTR_CLAMP)
            return {24'h0, bsrLatch[7:4], 4'hF};
        if (c == INSTR_HIGHZ)
            return 32'h0;
        return {24'h0, sysOut, sysOutEn};
    endfunction
    task automatic id_check();
        want(1'b0, ID_TB);
        i_bst_jtag_ctrl.scan(1'b0, $urandom, 32);
        seen();
    endtask
    task automatic run_code(input bst_instr_t c);
        logic [31:0] d;
        logic [31:0] p;
        d = $urandom;
        want(1'b0, {29'h0, IR_CAPTURE_VAL});
        i_bst_jtag_ctrl.scan(1'b1, {29'h0, c}, 3);
        seen();
        p = pinsExp(c);
        if (c == INSTR_IDCODE)
            want(1'b0, ID_TB);
        else if (c == INSTR_SAMPLE || c == INSTR_EXTEST)
            want(1'b0, {24'h0, p[7:4], pinIn});
        else
            want(1'b0, {24'h0, d[6:0], BYPASS_CAPTURE_VAL});
        i_bst_jtag_ctrl.scan(1'b0, d, (c == INSTR_IDCODE) ? 32 : 8);
        seen();
        if (c == INSTR_SAMPLE || c == INSTR_EXTEST)
            bsrLatch = d[7:0];
        want(1'b1, pinsExp(c));
        seen();
    endtask
    initial
    begin
        void'($urandom(69336));
        pinIn = 4'($urandom);
        sysOut = 4'($urandom);
        // Enables kept off all-zero and all-one so system mode stays tellable
        sysOutEn = 4'h1 | (4'($urandom) & 4'h6);
        // A start value gives the pin reset no falling edge, so it is lowered here
        @(posedge core_clk);
        #1;
        testResetPinN = 1'b0;
        repeat (11) @(posedge core_clk);
        #1;
        want(1'b1, 32'h0);
        seen();
        rst_n = 1'b1;
        testResetPinN = 1'b1;
        i_bst_jtag_ctrl.tap_reset();
        id_check();
        i_bst_jtag_ctrl.tap_reset();
        foreach (codes[i])
            run_code(codes[i]);
        i_bst_jtag_ctrl.walk(8'h07, 3);
        id_check();
        run_code(INSTR_EXTEST);
        @(posedge core_clk);
        #1;
        testResetPinN = 1'b0;
        repeat (10) @(posedge core_clk);
        #1;
        want(1'b1, {24'h0, sysOut, sysOutEn});
        seen();
        @(posedge core_clk);
        #1;
        testResetPinN = 1'b1;
        // System values move while the pins follow them, so the one-cycle pass is really checked
        repeat (3)
        begin
            @(posedge core_clk);
            #1;
            sysOut = 4'($urandom);
        end
        repeat (4) @(posedge core_clk);
        #1;
        want(1'b1, {24'h0, sysOut, sysOutEn});
        seen();
        i_bst_jtag_ctrl.tap_reset();
        i_bst_jtag_ctrl.walk(8'h1A, 6);
        id_check();
        test_done();
    end
endmodule // bst_tap_tb
bind bst_tap bst_tap_sva i_bst_tap_sva (.core_clk(core_clk), .rst_n(rst_n), .testClockPin(testClockPin),
    .testResetPinN(testResetPinN), .testModeSelectPin(testModeSelectPin), .testDataInPin(testDataInPin),
    .testDataOutPin(testDataOutPin), .testDataOutEn(testDataOutEn), .pinIn(pinIn), .sysOut(sysOut),
    .sysOutEn(sysOutEn), .pinOut(pinOut), .pinOutEn(pinOutEn));
